/* verilog/isk_core.sv */
// Execution of the increment and increment-skip instructions behind a Wishbone slave
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "isk_defs.svh"
module isk_core (
	input  wire logic        clock,      // 50 MHz core clock
	input  wire logic        reset,      // Asynchronous, active high
	input  wire logic        wb_cyc_i,   // Wishbone cycle
	input  wire logic        wb_stb_i,   // Wishbone strobe
	input  wire logic        wb_we_i,    // Wishbone write
	input  wire logic [7:0]  wb_adr_i,   // Byte address
	input  wire logic [3:0]  wb_sel_i,   // Byte enables
	input  wire logic [31:0] wb_dat_i,   // Write data
	output logic      [31:0] wb_dat_o,   // Read data
	output logic             wb_ack_o,   // Acknowledge
	output logic      [11:0] fr_addr_o,  // File register address, bank and offset
	output logic             fr_re_o,    // File register read strobe
	output logic             fr_we_o,    // File register write strobe
	output logic      [7:0]  fr_wdata_o, // File register write data
	input  wire logic [7:0]  fr_rdata_i, // Read data, one cycle after the strobe
	output logic             busy_o,     // Instruction in progress
	output logic      [1:0]  phase_o     // Current phase of the cycle
);

	isk_pkg::isk_state_e state_q, state_d;
	isk_pkg::isk_kind_e  kind_q;
	logic [15:0] instr_q;
	logic        two_word_q;
	logic [3:0]  bank_q;
	logic [7:0]  wreg_q;
	logic [4:0]  flags_q;
	logic [3:0]  nop_left_q;
	logic [1:0]  cycles_q;
	logic        last_skip_q, illegal_q, ack_q, busy_q, fr_re_q, fr_we_q;
	logic [1:0]  phase_q;
	logic [31:0] dat_q;
	logic [11:0] fr_addr_q;
	logic [7:0]  fr_wdata_q;
	logic [7:0]  sum_w;
	logic        c_w, dc_w, z_w, n_w, ov_w;

	// Classify an instruction word by its opcode
	function automatic isk_pkg::isk_kind_e op_kind(input logic [15:0] word);
		case (word[`ISK_OPC_HI:`ISK_OPC_LO])
			`ISK_OPC_INCREMENT_FILE: op_kind = isk_pkg::ISK_K_INC;
			`ISK_OPC_SKZ:  op_kind = isk_pkg::ISK_K_SKZ;
			`ISK_OPC_SKNZ: op_kind = isk_pkg::ISK_K_SKNZ;
			default:       op_kind = isk_pkg::ISK_K_NONE;
		endcase
	endfunction

	// Bus decode; writes land on the edge that the master sees ack
	wire req_w      = wb_cyc_i & wb_stb_i;
	wire wr_take_w  = req_w & wb_we_i & ack_q;
	wire wr_instr_w = wr_take_w & (wb_adr_i == `ISK_OFF_INSTR) & (&wb_sel_i[2:0]);
	wire wr_bank_w  = wr_take_w & (wb_adr_i == `ISK_OFF_BANK) & wb_sel_i[0];
	wire wr_wreg_w  = wr_take_w & (wb_adr_i == `ISK_OFF_WREG) & wb_sel_i[0];
	wire wr_flags_w = wr_take_w & (wb_adr_i == `ISK_OFF_FLAGS) & wb_sel_i[0];
	wire idle_w     = (state_q == isk_pkg::ISK_ST_IDLE);
	wire legal_w    = (op_kind(wb_dat_i[15:0]) != isk_pkg::ISK_K_NONE);
	wire start_w    = wr_instr_w & idle_w & legal_w;

	// Read mux; unmapped offsets read as zero
	wire [31:0] rd_w =
		(wb_adr_i == `ISK_OFF_INSTR) ? {15'h0000, two_word_q, instr_q} :
		(wb_adr_i == `ISK_OFF_BANK)  ? {28'h0000000, bank_q} :
		(wb_adr_i == `ISK_OFF_WREG)  ? {24'h000000, wreg_q} :
		(wb_adr_i == `ISK_OFF_FLAGS) ? {27'h0000000, flags_q} :
		(wb_adr_i == `ISK_OFF_EXEC)  ? {24'h000000, phase_q, 1'b0, illegal_q,
			cycles_q, last_skip_q, busy_q} : 32'h00000000;

	// Bank choice: access bank splits at the midpoint of the offset range
	wire [3:0] acc_bank_w = (instr_q[7:0] >= `ISK_ACCESS_SPLIT) ?
		`ISK_ACCESS_HI_BANK : `ISK_ACCESS_LO_BANK;
	wire [3:0] bank_use_w = instr_q[`ISK_BANK_BIT] ? bank_q : acc_bank_w;

	// Skip decision on the result held for the write phase
	wire res_zero_w = (fr_wdata_q == 8'h00);
	wire skip_w     = ((kind_q == isk_pkg::ISK_K_SKZ) & res_zero_w) |
		((kind_q == isk_pkg::ISK_K_SKNZ) & ~res_zero_w);
	wire is_inc_w   = (kind_q == isk_pkg::ISK_K_INC);
	wire [4:0] new_flags_w = {n_w, ov_w, z_w, dc_w, c_w};

	isk_incr_alu u_alu (
		.operand     (fr_rdata_i),
		.sum         (sum_w),
		.carry       (c_w),
		.digit_carry (dc_w),
		.zero        (z_w),
		.negative    (n_w),
		.overflow    (ov_w)
	);

	// Phase sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			isk_pkg::ISK_ST_IDLE: if (start_w) state_d = isk_pkg::ISK_ST_Q1;
			isk_pkg::ISK_ST_Q1:   state_d = isk_pkg::ISK_ST_Q2;
			isk_pkg::ISK_ST_Q2:   state_d = isk_pkg::ISK_ST_Q3;
			isk_pkg::ISK_ST_Q3:   state_d = isk_pkg::ISK_ST_Q4;
			isk_pkg::ISK_ST_Q4:   state_d = skip_w ? isk_pkg::ISK_ST_NOP : isk_pkg::ISK_ST_IDLE;
			isk_pkg::ISK_ST_NOP:  if (nop_left_q == 4'h1) state_d = isk_pkg::ISK_ST_IDLE;
			default:              state_d = isk_pkg::ISK_ST_IDLE;
		endcase
	end

	// Sequencer state and phase counter
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= isk_pkg::ISK_ST_IDLE;
			phase_q <= 2'h0;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= (idle_w || state_d == isk_pkg::ISK_ST_IDLE) ? 2'h0 : phase_q + 2'h1;
			busy_q  <= (state_d != isk_pkg::ISK_ST_IDLE);
		end
	end

	// Instruction capture; a write while busy is dropped, a bad opcode is captured and flagged illegal but not started
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			instr_q    <= `ISK_RST_INSTR;
			two_word_q <= 1'b0;
			kind_q     <= isk_pkg::ISK_K_NONE;
			illegal_q  <= 1'b0;
		end else if (wr_instr_w && idle_w) begin
			instr_q    <= wb_dat_i[15:0];
			two_word_q <= wb_dat_i[`ISK_TWO_WORD_BIT];
			kind_q     <= op_kind(wb_dat_i[15:0]);
			illegal_q  <= ~legal_w;
		end
	end

	// Skip length and cycle accounting
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			nop_left_q  <= 4'h0;
			cycles_q    <= 2'h0;
			last_skip_q <= 1'b0;
		end else if (state_q == isk_pkg::ISK_ST_Q4) begin
			nop_left_q  <= two_word_q ? `ISK_NOP_TWO : `ISK_NOP_ONE;
			cycles_q    <= skip_w ? (two_word_q ? 2'h3 : 2'h2) : 2'h1;
			last_skip_q <= skip_w;
		end else if (state_q == isk_pkg::ISK_ST_NOP) begin
			nop_left_q  <= nop_left_q - 4'h1; // No bus activity while idling
		end
	end

	// File register port, driven one phase ahead so it stands during the phase
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fr_addr_q  <= 12'h000;
			fr_re_q    <= 1'b0;
			fr_we_q    <= 1'b0;
			fr_wdata_q <= 8'h00;
		end else begin
			if (state_q == isk_pkg::ISK_ST_Q1)
				fr_addr_q <= {bank_use_w, instr_q[7:0]};
			fr_re_q <= (state_d == isk_pkg::ISK_ST_Q2);
			fr_we_q <= (state_d == isk_pkg::ISK_ST_Q4) & instr_q[`ISK_DEST_BIT];
			if (state_q == isk_pkg::ISK_ST_Q3)
				fr_wdata_q <= sum_w;
		end
	end

	// Working register; the instruction result wins over a bus write
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			wreg_q <= `ISK_RST_WREG;
		else if (state_q == isk_pkg::ISK_ST_Q4 && !instr_q[`ISK_DEST_BIT])
			wreg_q <= fr_wdata_q;
		else if (wr_wreg_w)
			wreg_q <= wb_dat_i[7:0];
	end

	// Status flags: only the plain increment touches them, and it beats a bus write
	logic [4:0] pend_flags_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flags_q      <= `ISK_RST_FLAGS;
			pend_flags_q <= `ISK_RST_FLAGS;
		end else begin
			if (state_q == isk_pkg::ISK_ST_Q3)
				pend_flags_q <= new_flags_w;
			if (state_q == isk_pkg::ISK_ST_Q4 && is_inc_w)
				flags_q <= pend_flags_q;
			else if (wr_flags_w)
				flags_q <= wb_dat_i[4:0];
		end
	end

	// Bank select register and bus answer, ack after one wait cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bank_q <= `ISK_RST_BANK;
			ack_q  <= 1'b0;
			dat_q  <= 32'h00000000;
		end else begin
			if (wr_bank_w)
				bank_q <= wb_dat_i[3:0];
			ack_q <= req_w & ~ack_q;
			dat_q <= rd_w;
		end
	end

	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = dat_q;
	assign fr_addr_o  = fr_addr_q;
	assign fr_re_o    = fr_re_q;
	assign fr_we_o    = fr_we_q;
	assign fr_wdata_o = fr_wdata_q;
	assign busy_o     = busy_q;
	assign phase_o    = phase_q;

	// Checks on phase order, addressing, results and skip length
	chk_phase_order: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q1 |=> state_q == isk_pkg::ISK_ST_Q2 ##1
		state_q == isk_pkg::ISK_ST_Q3 ##1 state_q == isk_pkg::ISK_ST_Q4 && fr_re_o == 1'b0)
		else $error("phases out of order");
	chk_read_strobe: assert property (@(posedge clock) disable iff (reset)
		fr_re_o |-> state_q == isk_pkg::ISK_ST_Q2)
		else $error("read strobe outside read phase");
	chk_sum_value: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 |-> fr_wdata_o == 8'($past(fr_rdata_i) + 8'h01))
		else $error("result is not operand plus one");
	chk_dest_file: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 |-> fr_we_o == instr_q[`ISK_DEST_BIT])
		else $error("file write does not follow destination bit");
	chk_dest_wreg: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 && !instr_q[`ISK_DEST_BIT] |=> wreg_q == $past(fr_wdata_o))
		else $error("working register missed the result");
	chk_bank_access: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q2 && !instr_q[`ISK_BANK_BIT] |->
		fr_addr_o == {((instr_q[7:0] < `ISK_ACCESS_SPLIT) ? `ISK_ACCESS_LO_BANK
		: `ISK_ACCESS_HI_BANK), instr_q[7:0]})
		else $error("access bank not used");
	chk_bank_select: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q2 && instr_q[`ISK_BANK_BIT] |->
		fr_addr_o[11:8] == $past(bank_q))
		else $error("bank select register not used");
	chk_wrap_flags: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 && is_inc_w && fr_wdata_o == 8'h00 |=>
		flags_q[`ISK_FLAG_C] && flags_q[`ISK_FLAG_DC] && flags_q[`ISK_FLAG_Z])
		else $error("wrap to zero did not set flags");
	chk_skip_flags: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 && !is_inc_w && !wr_flags_w |=> $stable(flags_q))
		else $error("skip instruction changed flags");
	chk_skip_one: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 && skip_w && !two_word_q |=>
		(state_q == isk_pkg::ISK_ST_NOP && !fr_we_o)[*4] ##1 state_q == isk_pkg::ISK_ST_IDLE)
		else $error("one-word skip not one idle cycle");
	chk_skip_two: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 && skip_w && two_word_q |=>
		(state_q == isk_pkg::ISK_ST_NOP && !fr_re_o)[*8] ##1 state_q == isk_pkg::ISK_ST_IDLE)
		else $error("two-word skip not two idle cycles");
	chk_no_skip: assert property (@(posedge clock) disable iff (reset)
		state_q == isk_pkg::ISK_ST_Q4 && !skip_w |=> state_q == isk_pkg::ISK_ST_IDLE)
		else $error("non-skip took extra cycles");

endmodule // isk_core

/* verilog/isk_defs.svh */
// Offsets, field positions, reset values and phase counts of the increment-skip block
// Overview of operation
// - Every increment instruction reads the addressed file register, adds one, and sends the sum to the chosen destination.
// - A clear destination bit writes the sum to the working register; a set one writes it back to the file register.
// - A clear bank bit addresses the fixed access bank; a set one takes the bank from the bank select register.
// - Opcode 0011 11da skips the fetched next instruction with an idle cycle when the sum is zero, leaving the flags alone.
// - Opcode 0100 10da skips the fetched next instruction with an idle cycle when the sum is nonzero, leaving the flags alone.
// - A skip over a two-word instruction costs three cycles in all, the extra ones doing nothing in any phase.
`ifndef ISK_DEFS_SVH
`define ISK_DEFS_SVH

// Register byte offsets
`define ISK_OFF_INSTR      8'h00
`define ISK_OFF_BANK       8'h04
`define ISK_OFF_WREG       8'h08
`define ISK_OFF_FLAGS      8'h0C
`define ISK_OFF_EXEC       8'h10

// Instruction fields and opcode patterns
`define ISK_OPC_HI         15
`define ISK_OPC_LO         10
`define ISK_DEST_BIT       9
`define ISK_BANK_BIT       8
`define ISK_TWO_WORD_BIT   16
`define ISK_OPC_INCREMENT_FILE       6'h0A
`define ISK_OPC_SKZ        6'h0F
`define ISK_OPC_SKNZ       6'h12

// Access bank layout
`define ISK_ACCESS_SPLIT   8'h80
`define ISK_ACCESS_LO_BANK 4'h0
`define ISK_ACCESS_HI_BANK 4'hF

// Flag positions
`define ISK_FLAG_C         0
`define ISK_FLAG_DC        1
`define ISK_FLAG_Z         2
`define ISK_FLAG_OV        3
`define ISK_FLAG_N         4

// Reset values
`define ISK_RST_BANK       4'h0
`define ISK_RST_WREG       8'h00
`define ISK_RST_FLAGS      5'h00
`define ISK_RST_INSTR      16'h0000

// Idle phases spent per skipped instruction word
`define ISK_NOP_ONE        4'h4
`define ISK_NOP_TWO        4'h8

`endif

/* verilog/isk_pkg.sv */
// Types shared by the increment-skip block
package isk_pkg;

	typedef enum logic [2:0] {
		ISK_ST_IDLE,
		ISK_ST_Q1,
		ISK_ST_Q2,
		ISK_ST_Q3,
		ISK_ST_Q4,
		ISK_ST_NOP
	} isk_state_e;

	typedef enum logic [1:0] {
		ISK_K_NONE,
		ISK_K_INC,
		ISK_K_SKZ,
		ISK_K_SKNZ
	} isk_kind_e;

endpackage

/* verilog/isk_incr_alu.sv */
// Eight-bit incrementer with its status flags
`timescale 1ns/100ps
module isk_incr_alu (
	input  wire logic [7:0] operand,     // Value read from the file register
	output logic      [7:0] sum,         // Operand plus one
	output logic            carry,       // Carry out of bit 7
	output logic            digit_carry, // Carry out of bit 3
	output logic            zero,        // Sum is zero
	output logic            negative,    // Bit 7 of sum
	output logic            overflow     // Signed overflow
);

	logic [8:0] wide_w;
	logic [4:0] low_w;

	// Ripple of a single added one
	assign wide_w      = {1'b0, operand} + 9'h001;
	assign low_w       = {1'b0, operand[3:0]} + 5'h01;
	assign sum         = wide_w[7:0];
	assign carry       = wide_w[8];
	assign digit_carry = low_w[4];
	assign zero        = (wide_w[7:0] == 8'h00);
	assign negative    = wide_w[7];
	assign overflow    = (operand == 8'h7F); // Only 0x7F crosses into negative

endmodule // isk_incr_alu

/* test/increment_skip_instructions_test.sv */
// Self-checking bench for the increment and increment-skip execution core
`timescale 1ns/100ps
`include "isk_defs.svh"
module increment_skip_instructions_test;
	logic        clock, reset, wb_cyc, wb_stb, wb_we;
	logic [7:0]  wb_adr, fr_rdata_i;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, fr_re_o, fr_we_o, busy_o;
	wire  [11:0] fr_addr_o;
	wire  [7:0]  fr_wdata_o;
	wire  [1:0]  phase_o;
	logic [7:0]  mem [0:4095];
	logic [11:0] seen_addr;
	logic [31:0] expq [$];
	logic [5:0]  opc [3] = '{`ISK_OPC_INCREMENT_FILE, `ISK_OPC_SKZ, `ISK_OPC_SKNZ};
	integer      seed = 32'hA548;
	int          err_total = 0;
	int          num_checks = 0;

	isk_core u_isk_core (
		.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fr_addr_o(fr_addr_o),
		.fr_re_o(fr_re_o), .fr_we_o(fr_we_o), .fr_wdata_o(fr_wdata_o),
		.fr_rdata_i(fr_rdata_i), .busy_o(busy_o), .phase_o(phase_o)
	);

	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// File RAM; outside a read the data line scrambles so stale values never pass
	always @(posedge clock) begin
		if (fr_re_o === 1'b1) begin
			fr_rdata_i <= mem[fr_addr_o];
			seen_addr  <= fr_addr_o;
		end else
			fr_rdata_i <= ~fr_rdata_i;
		if (fr_we_o === 1'b1)
			mem[fr_addr_o] <= fr_wdata_o;
	end

	task automatic finish_test();
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	// Read data is judged here, oldest note first; an unexpected ack meets X
	always @(posedge clock) begin
		if (wb_ack_o === 1'b1 && wb_we === 1'b0)
			check(wb_dat_o, (expq.size() > 0) ? expq.pop_front() : 'x);
	end

	// Classic single cycle, held until ack, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt,
		input logic [31:0] ex);
		@(posedge clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= w;
		wb_adr <= ad;
		wb_dat <= dt;
		wb_sel <= 4'hF;
		if (!w)
			expq.push_back(ex);
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// One instruction with random operands; boundary values every few passes
	task automatic run(input int i);
		logic [5:0]  op;
		logic        d, a, two, skip;
		logic [7:0]  f, val, sum, w0;
		logic [3:0]  bk;
		logic [4:0]  fl, efl;
		logic [11:0] ea;
		int          n, ncyc;
		op   = opc[i % 3];
		d    = ((i / 3) % 2) == 1;
		a    = ((i / 6) % 2) == 1;
		two  = ((i / 12) % 2) == 1;
		val  = (i % 4 == 0) ? 8'hFF : (i % 4 == 1) ? 8'h7F : 8'($random(seed));
		f    = 8'($random(seed));
		bk   = 4'($random(seed));
		fl   = 5'($random(seed));
		w0   = 8'($random(seed));
		ea   = a ? {bk, f} : {(f >= `ISK_ACCESS_SPLIT) ? `ISK_ACCESS_HI_BANK
			: `ISK_ACCESS_LO_BANK, f};
		sum  = val + 8'h01;
		skip = (op == `ISK_OPC_SKZ) ? (sum == 8'h00)
			: (op == `ISK_OPC_SKNZ) ? (sum != 8'h00) : 1'b0;
		efl  = (op == `ISK_OPC_INCREMENT_FILE) ? {sum[7], val == 8'h7F, sum == 8'h00,
			val[3:0] == 4'hF, val == 8'hFF} : fl;
		ncyc = skip ? (two ? 3 : 2) : 1;
		n    = 0;
		mem[ea] = val;
		wb(1'b1, `ISK_OFF_BANK, {28'h0, bk}, 32'h0);
		wb(1'b1, `ISK_OFF_FLAGS, {27'h0, fl}, 32'h0);
		wb(1'b1, `ISK_OFF_WREG, {24'h0, w0}, 32'h0);
		wb(1'b1, `ISK_OFF_INSTR, {15'h0, two, op, d, a, f}, 32'h0);
		// Counted on the falling edge, where busy has settled
		while (busy_o !== 1'b1) @(negedge clock);
		while (busy_o === 1'b1) begin
			check(phase_o, 32'(n % 4));
			n++;
			@(negedge clock);
		end
		check(n, ncyc * 4);
		check(seen_addr, ea);
		check(mem[ea], d ? sum : val);
		wb(1'b0, `ISK_OFF_WREG, 32'h0, {24'h0, d ? w0 : sum});
		wb(1'b0, `ISK_OFF_FLAGS, 32'h0, {27'h0, efl});
		wb(1'b0, `ISK_OFF_EXEC, 32'h0, {24'h0, 4'h0, 2'(ncyc), skip, 1'b0});
	endtask

	// Main sequence: reset values, unmapped place, then every form, d and a
	initial begin
		reset  = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we  = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_dat = 32'h0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		wb(1'b0, `ISK_OFF_BANK, 32'h0, 32'h0);
		wb(1'b0, `ISK_OFF_WREG, 32'h0, 32'h0);
		wb(1'b0, `ISK_OFF_FLAGS, 32'h0, 32'h0);
		wb(1'b0, `ISK_OFF_EXEC, 32'h0, 32'h0);
		wb(1'b1, 8'h14, 32'hFFFFFFFF, 32'h0);
		wb(1'b0, 8'h14, 32'h0, 32'h0);
		wb(1'b1, `ISK_OFF_BANK, 32'hFFFFFFFF, 32'h0);
		wb(1'b0, `ISK_OFF_BANK, 32'h0, 32'h0000000F);
		for (int i = 0; i < 24; i++)
			run(i);
		// A second instruction write while busy is dropped, the first runs on
		mem[12'h010] = 8'h41;
		wb(1'b1, `ISK_OFF_INSTR, 32'h00002A10, 32'h0);
		wb(1'b1, `ISK_OFF_INSTR, 32'h00013C55, 32'h0);
		while (busy_o === 1'b1) @(negedge clock);
		check(mem[12'h010], 32'h00000042);
		wb(1'b0, `ISK_OFF_INSTR, 32'h0, 32'h00002A10);
		// A bad opcode is captured and flagged but never runs
		wb(1'b1, `ISK_OFF_INSTR, 32'h0001FFFF, 32'h0);
		wb(1'b0, `ISK_OFF_INSTR, 32'h0, 32'h0001FFFF);
		wb(1'b0, `ISK_OFF_EXEC, 32'h0, 32'h00000014);
		// Reset as an instruction starts returns the bank and exec registers to their reset values
		wb(1'b1, `ISK_OFF_INSTR, 32'h00002A10, 32'h0);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		wb(1'b0, `ISK_OFF_BANK, 32'h0, 32'h0);
		wb(1'b0, `ISK_OFF_EXEC, 32'h0, 32'h0);
		repeat (2) @(posedge clock);
		check(expq.size(), 32'h0);
		finish_test();
	end

	// Watchdog, well beyond the several hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		finish_test();
	end
endmodule // increment_skip_instructions_test
